//--- src/fault_latch_auto_restart.sv
// Fault latch with manual clear paths and automatic reset and restart.
//
// Functional notes
// RULE_01 - A latched fault is not cleared while its cause is still present.
// RULE_02 - Up key held three seconds clears a fault whose cause is gone.
// RULE_03 - Writing 1 or 2 to the clear register clears a fault.
// RULE_04 - A cycled digital input set to function 7 clears a fault.
// RULE_05 - Nonzero retry count and delay: reset type 1 fault, then restart.
// RULE_06 - Nonzero count, zero delay: clear F4, F5, F8 without restarting.
// RULE_07 - Automatic restart resets the fault then starts, without any command.
// RULE_08 - Type 2 faults are never reset automatically.
// RULE_09 - Exhausted retries latch F33, type 2, cleared only manually.
// RULE_10 - Open auxiliary interlock latches F2, type 1.
// RULE_11 - Bus below 85 percent or single phase latches F3, type 2.
// RULE_12 - Bus under minimum latches F4, type 1.
// RULE_13 - Bus over maximum latches F5, type 1.
// RULE_14 - Motor that cannot accelerate latches F6, type 1.
// RULE_15 - Motor overload trip latches F7, type 1.
// RULE_16 - Heatsink over its limit latches F8, type 1.
// RULE_17 - Hardware overcurrent latches F12, type 2.
// RULE_18 - Ground fault at an output latches F13, type 2.
// RULE_19 - Analog input loss latches F29, type 1, only when so configured.
// RULE_20 - A latched fault shows its number with a flashing indicator.
// RULE_21 - Each attempt waits the delay, then decrements; manual clear reloads.
// RULE_22 - Code and type stay held until a clear succeeds or power goes.
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fault_defs.svh"

module fault_latch_auto_restart
  import fault_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = `FLT_HOLD_CYCLES,
  parameter int unsigned DELAY_UNIT_CYCLES = `FLT_DELAY_UNIT_CYCLES,
  parameter int unsigned FLASH_CYCLES = `FLT_FLASH_CYCLES
) (
  // Clock, reset and enable.
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Register port.
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Monitored conditions, asynchronous pins.
  input wire logic aux_open_i,
  input wire logic bus_low_i,
  input wire logic single_phase_i,
  input wire logic bus_under_i,
  input wire logic bus_over_i,
  input wire logic motor_stall_i,
  input wire logic motor_overload_i,
  input wire logic heatsink_hot_i,
  input wire logic hw_overcurrent_i,
  input wire logic ground_fault_i,
  input wire logic analog_loss_i,
  // Operator keypad and digital inputs, asynchronous pins.
  input wire logic key_up_i,
  input wire logic [3:0] digital_in_i,
  // Fault display and drive command.
  output logic [7:0] fault_code_o,
  output logic [1:0] fault_type_o,
  output logic fault_flash_o,
  output logic run_cmd_o
);

  fault_state_type q;
  fault_state_type next_q;
  logic [`FLT_SYNC_WIDTH-1:0] pins;
  logic [`FLT_SYNC_WIDTH-1:0] mon;
  logic key_done;
  logic param_clear;
  logic [3:0] din_hit;
  logic manual_clear;
  logic cause_present;
  logic [9:0] detected;
  logic delay_done;
  logic auto_clear_ok;

  ////////////////////////////////////////////////////////////////////////////////
  // Input conditioning.

  assign pins = {digital_in_i, key_up_i, analog_loss_i, ground_fault_i, hw_overcurrent_i,
                 heatsink_hot_i, motor_overload_i, motor_stall_i, bus_over_i, bus_under_i,
                 single_phase_i, bus_low_i, aux_open_i};

  input_sync u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .pin_i(pins),
    .sync_o(mon)
  );

  // RULE_02 three second hold
  hold_timer #(
    .HOLD_CYCLES(HOLD_CYCLES)
  ) u_hold (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .held_i(mon[`FLT_MON_KEY_UP]),
    .done_o(key_done)
  );

  // RULE_04 input cycle clear
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_din
      assign din_hit[g] = (q.in_sel[g*4 +: 4] == `FLT_SEL_CLEAR_FAULT) &&
                          mon[`FLT_MON_DIN + g] && !q.din_prev[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Fault detection.

  // Returns whether the cause behind a given fault number is still present.
  function automatic logic cause_of(input logic [7:0] code,
                                    input logic [`FLT_SYNC_WIDTH-1:0] m,
                                    input logic analog_en);
    case (code)
      `FLT_CODE_AUX: cause_of = m[`FLT_MON_AUX];
      `FLT_CODE_POWER_LOSS: cause_of = m[`FLT_MON_BUS_LOW] | m[`FLT_MON_SINGLE_PH];
      `FLT_CODE_UNDER_V: cause_of = m[`FLT_MON_UNDER_V];
      `FLT_CODE_OVER_V: cause_of = m[`FLT_MON_OVER_V];
      `FLT_CODE_STALL: cause_of = m[`FLT_MON_STALL];
      `FLT_CODE_OVERLOAD: cause_of = m[`FLT_MON_OVERLOAD];
      `FLT_CODE_HEATSINK: cause_of = m[`FLT_MON_HEATSINK];
      `FLT_CODE_HW_OC: cause_of = m[`FLT_MON_HW_OC];
      `FLT_CODE_GROUND: cause_of = m[`FLT_MON_GROUND];
      `FLT_CODE_ANALOG: cause_of = m[`FLT_MON_ANALOG] & analog_en;
      default: cause_of = 1'b0;
    endcase
  endfunction

  // Picks the fault to latch as {type, code}; type 2 faults win over type 1.
  function automatic logic [9:0] pick_fault(input logic [`FLT_SYNC_WIDTH-1:0] m,
                                            input logic analog_en);
    // RULE_18 ground fault
    if (m[`FLT_MON_GROUND]) pick_fault = {FT_PERMANENT, `FLT_CODE_GROUND};
    // RULE_17 hardware overcurrent
    else if (m[`FLT_MON_HW_OC]) pick_fault = {FT_PERMANENT, `FLT_CODE_HW_OC};
    // RULE_11 power loss
    else if (m[`FLT_MON_BUS_LOW] | m[`FLT_MON_SINGLE_PH])
      pick_fault = {FT_PERMANENT, `FLT_CODE_POWER_LOSS};
    // RULE_10 auxiliary interlock
    else if (m[`FLT_MON_AUX]) pick_fault = {FT_RESETTABLE, `FLT_CODE_AUX};
    // RULE_12 bus undervoltage
    else if (m[`FLT_MON_UNDER_V]) pick_fault = {FT_RESETTABLE, `FLT_CODE_UNDER_V};
    // RULE_13 bus overvoltage
    else if (m[`FLT_MON_OVER_V]) pick_fault = {FT_RESETTABLE, `FLT_CODE_OVER_V};
    // RULE_14 motor stall
    else if (m[`FLT_MON_STALL]) pick_fault = {FT_RESETTABLE, `FLT_CODE_STALL};
    // RULE_15 motor overload
    else if (m[`FLT_MON_OVERLOAD]) pick_fault = {FT_RESETTABLE, `FLT_CODE_OVERLOAD};
    // RULE_16 heatsink overtemperature
    else if (m[`FLT_MON_HEATSINK]) pick_fault = {FT_RESETTABLE, `FLT_CODE_HEATSINK};
    // RULE_19 configured analog loss
    else if (m[`FLT_MON_ANALOG] & analog_en) pick_fault = {FT_RESETTABLE, `FLT_CODE_ANALOG};
    else pick_fault = {FT_NONE, `FLT_CODE_NONE};
  endfunction

  assign cause_present = cause_of(q.code, mon, q.analog_cfg != 8'h00);
  assign detected = pick_fault(mon, q.analog_cfg != 8'h00);
  // RULE_03 clear by write
  assign param_clear = wr_i && (addr_i == `FLT_ADDR_CLEAR) &&
                       ((wdata_i == {24'h00_0000, `FLT_CLEAR_VAL_A}) ||
                        (wdata_i == {24'h00_0000, `FLT_CLEAR_VAL_B}));
  assign manual_clear = key_done | param_clear | (|din_hit);
  assign delay_done = (q.unit_cnt == DELAY_UNIT_CYCLES - 32'h0000_0001) &&
                      (q.delay_units == q.retry_delay - 8'h01);
  // RULE_06 bus voltage and heatsink only
  assign auto_clear_ok = (q.code == `FLT_CODE_UNDER_V) || (q.code == `FLT_CODE_OVER_V) ||
                         (q.code == `FLT_CODE_HEATSINK);

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    next_q = q;
    next_q.run_cmd = 1'b0;
    next_q.rdata = 32'h0000_0000;
    next_q.din_prev = mon[`FLT_MON_DIN +: 4];

    if (wr_i) begin
      case (addr_i)
        `FLT_ADDR_CLEAR: next_q.clear_param = wdata_i[7:0];
        `FLT_ADDR_RETRY_COUNT: begin
          next_q.retry_count = wdata_i[7:0];
          next_q.remaining = wdata_i[7:0];
        end
        `FLT_ADDR_RETRY_DELAY: next_q.retry_delay = wdata_i[7:0];
        `FLT_ADDR_SEL0: next_q.in_sel[3:0] = wdata_i[3:0];
        `FLT_ADDR_SEL1: next_q.in_sel[7:4] = wdata_i[3:0];
        `FLT_ADDR_SEL2: next_q.in_sel[11:8] = wdata_i[3:0];
        `FLT_ADDR_SEL3: next_q.in_sel[15:12] = wdata_i[3:0];
        `FLT_ADDR_ANALOG_CFG: next_q.analog_cfg = wdata_i[7:0];
        default: ;
      endcase
    end

    if (rd_i) begin
      case (addr_i)
        `FLT_ADDR_CLEAR: next_q.rdata = {24'h00_0000, q.clear_param};
        `FLT_ADDR_RETRY_COUNT: next_q.rdata = {24'h00_0000, q.retry_count};
        `FLT_ADDR_RETRY_DELAY: next_q.rdata = {24'h00_0000, q.retry_delay};
        `FLT_ADDR_SEL0: next_q.rdata = {28'h000_0000, q.in_sel[3:0]};
        `FLT_ADDR_SEL1: next_q.rdata = {28'h000_0000, q.in_sel[7:4]};
        `FLT_ADDR_SEL2: next_q.rdata = {28'h000_0000, q.in_sel[11:8]};
        `FLT_ADDR_SEL3: next_q.rdata = {28'h000_0000, q.in_sel[15:12]};
        `FLT_ADDR_ANALOG_CFG: next_q.rdata = {24'h00_0000, q.analog_cfg};
        `FLT_ADDR_STATUS: begin
          next_q.rdata[`FLT_STAT_CODE_LSB +: 8] = q.code;
          next_q.rdata[`FLT_STAT_TYPE_LSB +: 2] = q.ftype;
          next_q.rdata[`FLT_STAT_STATE_LSB +: 4] = q.st;
        end
        `FLT_ADDR_REMAIN: next_q.rdata = {24'h00_0000, q.remaining};
        default: next_q.rdata = 32'h0000_0000;
      endcase
    end

    // RULE_20 flashing fault display
    if (q.code == `FLT_CODE_NONE) begin
      next_q.flash_cnt = 32'h0000_0000;
      next_q.flash = 1'b0;
    end else if (q.flash_cnt == FLASH_CYCLES - 32'h0000_0001) begin
      next_q.flash_cnt = 32'h0000_0000;
      next_q.flash = !q.flash;
    end else begin
      next_q.flash_cnt = q.flash_cnt + 32'h0000_0001;
    end

    case (q.st)
      ST_CLEAR: begin
        if (detected[7:0] != `FLT_CODE_NONE) begin
          next_q.code = detected[7:0];
          next_q.ftype = fault_class_type'(detected[9:8]);
          next_q.st = ST_FAULTED;
        end
      end
      ST_FAULTED, ST_WAIT: begin
        next_q.unit_cnt = 32'h0000_0000;
        next_q.delay_units = 8'h00;
        // RULE_01 cause must be gone
        if (manual_clear && !cause_present) begin
          next_q.code = `FLT_CODE_NONE;
          next_q.ftype = FT_NONE;
          next_q.st = ST_CLEAR;
          // RULE_21 reload on manual clear
          next_q.remaining = q.retry_count;
        // RULE_08 type 2 waits for an operator
        end else if (q.ftype == FT_RESETTABLE && q.retry_count != 8'h00) begin
          if (q.retry_delay == 8'h00) begin
            // RULE_06 clear without restart
            if (auto_clear_ok && !cause_present) begin
              next_q.code = `FLT_CODE_NONE;
              next_q.ftype = FT_NONE;
              next_q.st = ST_CLEAR;
            end
          end else if (q.remaining == 8'h00) begin
            // RULE_09 retries used up
            next_q.code = `FLT_CODE_RETRY;
            next_q.ftype = FT_PERMANENT;
            next_q.st = ST_FAULTED;
          end else if (q.st == ST_FAULTED) begin
            next_q.st = ST_WAIT;
          end else if (delay_done) begin
            // RULE_21 one attempt per delay
            next_q.remaining = q.remaining - 8'h01;
            if (!cause_present) begin
              // RULE_05 reset then restart
              next_q.code = `FLT_CODE_NONE;
              next_q.ftype = FT_NONE;
              next_q.st = ST_RESTART;
            end
          end else if (q.unit_cnt == DELAY_UNIT_CYCLES - 32'h0000_0001) begin
            next_q.delay_units = q.delay_units + 8'h01;
          end else begin
            next_q.unit_cnt = q.unit_cnt + 32'h0000_0001;
            next_q.delay_units = q.delay_units;
          end
        end else begin
          // RULE_22 held until cleared
          next_q.st = ST_FAULTED;
        end
      end
      ST_RESTART: begin
        // RULE_07 own start command
        next_q.run_cmd = 1'b1;
        next_q.st = ST_CLEAR;
      end
      default: next_q.st = ST_CLEAR;
    endcase
  end

  // The clock enable freezes every field, the read data included.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.st <= ST_CLEAR;
      q.ftype <= FT_NONE;
      q.retry_count <= `FLT_RST_RETRY_COUNT;
      q.retry_delay <= `FLT_RST_RETRY_DELAY;
      q.analog_cfg <= `FLT_RST_ANALOG_CFG;
      q.remaining <= `FLT_RST_RETRY_COUNT;
    end else if (ce_i) begin
      q <= next_q;
    end
  end

  assign rdata_o = q.rdata;
  assign fault_code_o = q.code;
  assign fault_type_o = q.ftype;
  assign fault_flash_o = q.flash;
  assign run_cmd_o = q.run_cmd;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_enter_restart;
    ce_i && q.st == ST_RESTART;
  endsequence

  sequence s_run_pulse;
    run_cmd_o && fault_code_o == `FLT_CODE_NONE ##1 !run_cmd_o || !ce_i;
  endsequence

  a_cause_blocks: assert property ( // RULE_01
    (q.code != `FLT_CODE_NONE && cause_present) |=> fault_code_o != `FLT_CODE_NONE
  ) else $error("Fault cleared while its cause was present.");

  a_key_clear: assert property ( // RULE_02
    (ce_i && key_done && q.code != `FLT_CODE_NONE && q.st != ST_RESTART && !cause_present)
      |=> fault_code_o == `FLT_CODE_NONE
  ) else $error("Keypad hold did not clear the fault.");

  a_param_clear: assert property ( // RULE_03
    (ce_i && wr_i && addr_i == `FLT_ADDR_CLEAR && wdata_i == 32'h0000_0002 &&
     q.code != `FLT_CODE_NONE && !cause_present) |=> fault_code_o == `FLT_CODE_NONE
  ) else $error("Clear write did not clear the fault.");

  a_input_clear: assert property ( // RULE_04
    (ce_i && (|din_hit) && q.code != `FLT_CODE_NONE && !cause_present)
      |=> fault_code_o == `FLT_CODE_NONE
  ) else $error("Digital input cycle did not clear the fault.");

  a_auto_restart: assert property ( // RULE_05
    s_enter_restart |=> s_run_pulse
  ) else $error("Restart state did not give one clean run command.");

  a_no_restart: assert property ( // RULE_06
    (q.retry_delay == 8'h00 && !(ce_i && wr_i)) |=> !run_cmd_o [*2]
  ) else $error("Run command issued with a zero retry delay.");

  a_type2_held: assert property ( // RULE_08
    (ce_i && q.ftype == FT_PERMANENT && !manual_clear)
      |=> fault_type_o == FT_PERMANENT && $stable(fault_code_o)
  ) else $error("Type 2 fault changed without a manual clear.");

  a_retry_exhaust: assert property ( // RULE_09
    (ce_i && q.st == ST_WAIT && q.ftype == FT_RESETTABLE && q.remaining == 8'h00 &&
     q.retry_delay != 8'h00 && q.retry_count != 8'h00 && !manual_clear)
      |=> fault_code_o == `FLT_CODE_RETRY && fault_type_o == FT_PERMANENT
  ) else $error("Exhausted retries did not latch the retry fault.");

  a_flash_idle: assert property ( // RULE_20
    (fault_code_o == `FLT_CODE_NONE) [*2] |-> !fault_flash_o
  ) else $error("Fault indicator flashing with no fault latched.");

  a_attempt_count: assert property ( // RULE_21
    (ce_i && q.st == ST_WAIT && delay_done && !manual_clear && q.remaining != 8'h00 &&
     q.ftype == FT_RESETTABLE && !(wr_i && addr_i == `FLT_ADDR_RETRY_COUNT))
      |=> q.remaining == $past(q.remaining) - 8'h01
  ) else $error("Retry attempt did not use up one retry.");

endmodule
`default_nettype wire

//--- src/fault_defs.svh
// Offsets, field positions, reset values, fault codes and timing counts of the fault block.
`ifndef FAULT_DEFS_SVH
`define FAULT_DEFS_SVH

// Clock rate and the times that become cycle counts.
`define FLT_CLK_MHZ 100
`define FLT_HOLD_TIME_MS 3000
`define FLT_HOLD_CYCLES (`FLT_HOLD_TIME_MS * `FLT_CLK_MHZ * 1000)
`define FLT_DELAY_UNIT_MS 1000
`define FLT_DELAY_UNIT_CYCLES (`FLT_DELAY_UNIT_MS * `FLT_CLK_MHZ * 1000)
`define FLT_FLASH_MS 500
`define FLT_FLASH_CYCLES (`FLT_FLASH_MS * `FLT_CLK_MHZ * 1000)

// Register byte addresses.
`define FLT_ADDR_CLEAR 8'h00
`define FLT_ADDR_RETRY_COUNT 8'h04
`define FLT_ADDR_RETRY_DELAY 8'h08
`define FLT_ADDR_SEL0 8'h0C
`define FLT_ADDR_SEL1 8'h10
`define FLT_ADDR_SEL2 8'h14
`define FLT_ADDR_SEL3 8'h18
`define FLT_ADDR_ANALOG_CFG 8'h1C
`define FLT_ADDR_STATUS 8'h20
`define FLT_ADDR_REMAIN 8'h24

// Reset values of the writable registers.
`define FLT_RST_RETRY_COUNT 8'h00
`define FLT_RST_RETRY_DELAY 8'h00
`define FLT_RST_SEL 4'h0
`define FLT_RST_ANALOG_CFG 8'h00

// Command values and input function selection.
`define FLT_CLEAR_VAL_A 8'h01
`define FLT_CLEAR_VAL_B 8'h02
`define FLT_SEL_CLEAR_FAULT 4'h7

// Fault numbers as binary values.
`define FLT_CODE_NONE 8'h00
`define FLT_CODE_AUX 8'h02
`define FLT_CODE_POWER_LOSS 8'h03
`define FLT_CODE_UNDER_V 8'h04
`define FLT_CODE_OVER_V 8'h05
`define FLT_CODE_STALL 8'h06
`define FLT_CODE_OVERLOAD 8'h07
`define FLT_CODE_HEATSINK 8'h08
`define FLT_CODE_HW_OC 8'h0C
`define FLT_CODE_GROUND 8'h0D
`define FLT_CODE_ANALOG 8'h1D
`define FLT_CODE_RETRY 8'h21

// Bit positions in the synchronised input vector.
`define FLT_MON_AUX 0
`define FLT_MON_BUS_LOW 1
`define FLT_MON_SINGLE_PH 2
`define FLT_MON_UNDER_V 3
`define FLT_MON_OVER_V 4
`define FLT_MON_STALL 5
`define FLT_MON_OVERLOAD 6
`define FLT_MON_HEATSINK 7
`define FLT_MON_HW_OC 8
`define FLT_MON_GROUND 9
`define FLT_MON_ANALOG 10
`define FLT_MON_KEY_UP 11
`define FLT_MON_DIN 12
`define FLT_SYNC_WIDTH 16

// Status register field positions.
`define FLT_STAT_CODE_LSB 0
`define FLT_STAT_TYPE_LSB 8
`define FLT_STAT_STATE_LSB 12

`endif

//--- src/fault_pkg.sv
// Types shared by the fault latch and auto restart design.
package fault_pkg;

  typedef enum logic [3:0] {
    ST_CLEAR = 4'b0001,
    ST_FAULTED = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_RESTART = 4'b1000
  } restart_state_type;

  typedef enum logic [1:0] {
    FT_NONE = 2'h0,
    FT_RESETTABLE = 2'h1,
    FT_PERMANENT = 2'h2
  } fault_class_type;

  typedef struct packed {
    logic [31:0] cnt;
    logic done;
  } hold_state_type;

  typedef struct packed {
    logic [15:0] meta;
    logic [15:0] sync;
  } sync_state_type;

  typedef struct packed {
    restart_state_type st;
    logic [7:0] code;
    fault_class_type ftype;
    logic [7:0] clear_param;
    logic [7:0] retry_count;
    logic [7:0] retry_delay;
    logic [7:0] analog_cfg;
    logic [15:0] in_sel;
    logic [7:0] remaining;
    logic [31:0] unit_cnt;
    logic [7:0] delay_units;
    logic [31:0] flash_cnt;
    logic flash;
    logic [3:0] din_prev;
    logic run_cmd;
    logic [31:0] rdata;
  } fault_state_type;

endpackage

//--- src/input_sync.sv
// Two-stage synchroniser for the monitor, keypad and digital input pins.
`timescale 1ns/1ps
`default_nettype none
`include "fault_defs.svh"

module input_sync
  import fault_pkg::*;
(
  // Clock, reset and enable.
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Pins and their synchronised copy.
  input wire logic [`FLT_SYNC_WIDTH-1:0] pin_i,
  output logic [`FLT_SYNC_WIDTH-1:0] sync_o
);

  sync_state_type q;
  sync_state_type next_q;

  // The first stage feeds only the second stage.
  always_comb begin
    next_q.meta = pin_i;
    next_q.sync = q.meta;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= next_q;
    end
  end

  assign sync_o = q.sync;

endmodule
`default_nettype wire

//--- src/hold_timer.sv
// Press-and-hold detector: one pulse once a key has been held for the full hold time.
`timescale 1ns/1ps
`default_nettype none

module hold_timer
  import fault_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = 32'h11E1_A300
) (
  // Clock, reset and enable.
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Held level in, done pulse out.
  input wire logic held_i,
  output logic done_o
);

  hold_state_type q;
  hold_state_type next_q;

  // A release restarts the count, so short presses never reach the end.
  always_comb begin
    next_q = q;
    next_q.done = 1'b0;
    if (!held_i) begin
      next_q.cnt = 32'h0000_0000;
    end else if (q.cnt < HOLD_CYCLES) begin
      next_q.cnt = q.cnt + 32'h0000_0001;
      next_q.done = (q.cnt == HOLD_CYCLES - 32'h0000_0001);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= next_q;
    end
  end

  assign done_o = q.done;

endmodule
`default_nettype wire

//--- bench/operator_panel.sv
// Keypad model: holds the up key for a requested number of cycles.
`timescale 1ns/1ps
`default_nettype none

module operator_panel (
  // Clock and press request.
  input wire logic sys_clk_i,
  input wire logic go_i,
  input wire logic [7:0] len_i,
  // Key pin.
  output logic key_up_o
);
  logic [7:0] left = 8'h00;

  always @(posedge sys_clk_i) begin
    if (go_i) begin
      left <= len_i;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end
  assign key_up_o = (left != 8'h00);
endmodule

`default_nettype wire

//--- bench/tb.sv
// Self-checking bench for the fault latch and auto restart block.
`timescale 1ns/1ps
`default_nettype none
`include "fault_defs.svh"

module tb;
  import fault_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic go = 1'b0;
  logic ce = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] len = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic [10:0] mon = 11'h000;
  logic [3:0] din = 4'h0;
  logic [31:0] v;
  wire logic [31:0] rdata_o;
  wire logic [7:0] code;
  wire logic [1:0] ftype;
  wire logic flash, run, key;
  int bad_count = 0;
  int comparisons = 0;
  int runs = 0;
  logic [7:0] row_code [11] = '{`FLT_CODE_AUX, `FLT_CODE_POWER_LOSS, `FLT_CODE_POWER_LOSS,
    `FLT_CODE_UNDER_V, `FLT_CODE_OVER_V, `FLT_CODE_STALL, `FLT_CODE_OVERLOAD,
    `FLT_CODE_HEATSINK, `FLT_CODE_HW_OC, `FLT_CODE_GROUND, `FLT_CODE_ANALOG};
  logic [1:0] row_type [11] = '{2'h1, 2'h2, 2'h2, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h1};

  always #5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) if (run === 1'b1) runs++;

  // Short counts keep every hold, delay and flash period a few cycles long.
  fault_latch_auto_restart #(.HOLD_CYCLES(20), .DELAY_UNIT_CYCLES(5), .FLASH_CYCLES(4))
    i_fault_latch_auto_restart (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .aux_open_i(mon[0]), .bus_low_i(mon[1]), .single_phase_i(mon[2]), .bus_under_i(mon[3]),
    .bus_over_i(mon[4]), .motor_stall_i(mon[5]), .motor_overload_i(mon[6]),
    .heatsink_hot_i(mon[7]), .hw_overcurrent_i(mon[8]), .ground_fault_i(mon[9]),
    .analog_loss_i(mon[10]), .key_up_i(key), .digital_in_i(din), .fault_code_o(code),
    .fault_type_o(ftype), .fault_flash_o(flash), .run_cmd_o(run));
  operator_panel i_operator_panel (.sys_clk_i(sys_clk_i), .go_i(go), .len_i(len),
    .key_up_o(key));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  task automatic sm(input int b, input logic x);
    @(posedge sys_clk_i);
    mon[b] <= x;
  endtask
  task automatic press(input logic [7:0] n);
    @(posedge sys_clk_i);
    go <= 1'b1;
    len <= n;
    @(posedge sys_clk_i);
    go <= 1'b0;
  endtask
  task automatic pulse_din(input int b);
    @(posedge sys_clk_i);
    din[b] <= 1'b1;
    cyc(5);
    din[b] <= 1'b0;
  endtask
  task automatic wait_code(input logic [7:0] e);
    for (int i = 0; i < 300; i++) begin
      cyc(1);
      if (code === e) break;
    end
    chk(code, e, "fault code wait");
    if (code !== e) stop_test();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    cyc(2);
    chk({code, ftype, flash, run}, 32'h0, "outputs after reset");
    rd(`FLT_ADDR_RETRY_COUNT);
    chk(v, 32'h0, "retry count reset");
    rd(8'h30);
    chk(v, 32'h0, "unmapped read");
    $display("test reset done");
    sm(10, 1'b1);
    cyc(10);
    chk(code, 32'h0, "analog loss unconfigured");
    sm(10, 1'b0);
    wr(`FLT_ADDR_ANALOG_CFG, 32'h1);
    for (int i = 0; i < 11; i++) begin
      sm(i, 1'b1);
      wait_code(row_code[i]);
      chk(ftype, row_type[i], "fault type");
      sm(i, 1'b0);
      cyc(3);
      wr(`FLT_ADDR_CLEAR, 32'h1);
      wait_code(8'h00);
    end
    $display("test table done");
    sm(0, 1'b1);
    wait_code(8'h02);
    wr(`FLT_ADDR_CLEAR, 32'h1);
    cyc(5);
    chk(code, 32'h02, "clear with cause present");
    v = flash;
    cyc(4);
    chk(flash, !v[0], "flash toggle");
    @(posedge sys_clk_i) ce <= 1'b0;
    #1 v = flash;
    cyc(8);
    chk(flash, v[0], "frozen by enable");
    ce <= 1'b1;
    sm(0, 1'b0);
    cyc(8);
    chk(code, 32'h02, "held after cause gone");
    wr(`FLT_ADDR_CLEAR, 32'h2);
    wait_code(8'h00);
    $display("test refuse done");
    sm(5, 1'b1);
    wait_code(8'h06);
    sm(5, 1'b0);
    press(8'h0A);
    cyc(40);
    chk(code, 32'h06, "short key press");
    press(8'h28);
    wait_code(8'h00);
    $display("test keypad done");
    wr(`FLT_ADDR_SEL2, 32'h7);
    sm(6, 1'b1);
    wait_code(8'h07);
    sm(6, 1'b0);
    pulse_din(1);
    cyc(10);
    chk(code, 32'h07, "unselected input");
    pulse_din(2);
    wait_code(8'h00);
    $display("test digital done");
    wr(`FLT_ADDR_RETRY_COUNT, 32'h2);
    rd(`FLT_ADDR_REMAIN);
    chk(v, 32'h2, "remaining loaded");
    wr(`FLT_ADDR_RETRY_DELAY, 32'h1);
    runs = 0;
    sm(3, 1'b1);
    wait_code(8'h04);
    sm(3, 1'b0);
    wait_code(8'h00);
    cyc(3);
    chk(runs, 32'h1, "restart pulse");
    rd(`FLT_ADDR_REMAIN);
    chk(v, 32'h1, "remaining decremented");
    sm(9, 1'b1);
    wait_code(8'h0D);
    sm(9, 1'b0);
    cyc(60);
    chk(code, 32'h0D, "type 2 not auto");
    wr(`FLT_ADDR_CLEAR, 32'h1);
    wait_code(8'h00);
    sm(5, 1'b1);
    wait_code(8'h21);
    chk(ftype, 32'h2, "exhausted type");
    sm(5, 1'b0);
    cyc(60);
    chk(code, 32'h21, "exhausted stays");
    rd(`FLT_ADDR_STATUS);
    chk(v, 32'h0000_2221, "status word");
    wr(`FLT_ADDR_CLEAR, 32'h1);
    wait_code(8'h00);
    $display("test auto done");
    wr(`FLT_ADDR_RETRY_DELAY, 32'h0);
    runs = 0;
    sm(4, 1'b1);
    wait_code(8'h05);
    sm(4, 1'b0);
    wait_code(8'h00);
    cyc(10);
    chk(runs, 32'h0, "no restart");
    $display("test zero delay done");
    sm(1, 1'b1);
    wait_code(8'h03);
    @(posedge sys_clk_i) rst_n_i <= 1'b0;
    cyc(2);
    chk({code, ftype}, 32'h0, "cleared by reset");
    rst_n_i <= 1'b1;
    cyc(2);
    chk(code, 32'h0, "no latch before sync");
    wait_code(8'h03);
    $display("test reset again done");
    stop_test();
  end
endmodule

`default_nettype wire
